// *** rtl/aps_pkg.sv ***
`default_nettype none
package aps_pkg;
    // Wishbone register map
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam logic [3:0] REG_SAMPLE = 4'hc;

    // Configuration byte fields
    localparam int CFG_PWR_HI   = 7;
    localparam int CFG_PWR_LO   = 6;
    localparam int CFG_ACQ_SRC  = 5;
    localparam int CFG_RANGE    = 4;
    localparam int CFG_POLARITY = 3;
    localparam int CFG_CH_HI    = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;

    localparam logic [1:0] PWR_NORM_EXT = 2'h0;
    localparam logic [1:0] PWR_NORM_INT = 2'h1;

    // Status register fields
    localparam int STS_DONE    = 0;
    localparam int STS_BUSY    = 1;
    localparam int STS_CLK_INT = 2;
    localparam int STS_PWRDN   = 3;
    localparam int STS_BAD_CH  = 4;
    localparam int STS_ST_LO   = 5;

    localparam logic [2:0]  CH_LAST      = 3'h5;
    localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // Conversion clock periods per phase
    localparam logic [3:0] ACQ_TICKS  = 4'h6;
    localparam logic [3:0] CONV_TICKS = 4'hc;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYS_CLK_KHZ   = 10000;
    localparam int OSC_KHZ       = 1560;
    localparam int OSC_DIV       = SYS_CLK_KHZ / OSC_KHZ;
    localparam logic [2:0] OSC_DIV_M1 = 3'(OSC_DIV - 1);
    localparam int T_DONE_CLR_NS = 120;
    localparam int T_RELEASE_NS  = 70;
    localparam int DONE_CLR_CYC  = (T_DONE_CLR_NS / CLK_PERIOD_NS) < 1 ?
                                   1 : T_DONE_CLR_NS / CLK_PERIOD_NS;
    localparam int RELEASE_CYC   = (T_RELEASE_NS / CLK_PERIOD_NS) < 1 ?
                                   1 : T_RELEASE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACQ_INT = 2'b01,
        ST_ACQ_EXT = 2'b10,
        ST_CONV    = 2'b11
    } aps_state_t;

    typedef struct packed {
        logic        cs_n;
        logic        wr_n;
        logic        rd_n;
        logic [11:0] data;
    } aps_pins_t;

    typedef struct packed {
        aps_state_t  st;
        logic [3:0]  cnt;
        logic [7:0]  cfg;
        logic        clk_int;
        logic [11:0] result;
        logic [11:0] sample;
        logic        bad_ch;
        logic        done_n;
        logic [11:0] dout;
        logic        oe;
        logic        wr_n_p;
        logic        rd_n_p;
        logic        ack;
        logic [31:0] rdat;
    } aps_core_t;

    typedef struct packed {
        logic [2:0] div;
        logic       ext_p;
        logic       tick;
    } aps_clk_t;
endpackage : aps_pkg
`default_nettype wire

// *** rtl/aps_conv_clk.sv ***
`default_nettype none
// Conversion clock tick: on-chip divider or sampled external pin
module aps_conv_clk (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic int_sel_i,
    input  wire logic ext_clk_i,
    output logic      tick_o
);
    aps_pkg::aps_clk_t s, n;

    always_comb begin
        n = s;
        n.ext_p = ext_clk_i;
        n.tick = 1'b0;
        if (int_sel_i) begin
            if (s.div == aps_pkg::OSC_DIV_M1) begin
                n.div = 3'h0;
                n.tick = 1'b1;
            end else begin
                n.div = s.div + 3'h1;
            end
        end else begin
            n.div = 3'h0;
            n.tick = ext_clk_i & ~s.ext_p;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick_o = s.tick;

    // A switch to the external pin may end the period early
    chk_osc_period: assert property (@(posedge clk_i)
        disable iff (rst_i)
        int_sel_i && $past(int_sel_i) && s.tick
        |=> (!s.tick || !int_sel_i) [*5] ##1 (s.tick || !int_sel_i))
        else $error("internal conversion clock period wrong");
endmodule // aps_conv_clk
`default_nettype wire

// *** rtl/aps_sequencer.sv ***
`default_nettype none
// Notes on behaviour
// - Done output goes low when result ready.
// - Read falling edge starts driving result.
// - Internal acquisition: write rise latches, acquires, converts.
// - External acquisition: first write acquires, second converts.
// - Internal clock mode uses on-chip oscillator.
// - Twelve bidirectional data lines, line 11 MSB.
// - Read clears done within 120 ns.
// - Lines released within 70 ns after read; the code releases them on the next clock edge after read rises, up to 100 ns.
// - Select high ignores strobes, lines float.
// - Configuration byte fields; internal acquisition six clocks.
// - Power field: ext, int, standby, full down.
// - Unipolar straight binary, bipolar twos complement.
module aps_sequencer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cs_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        rd_n_i,
    input  wire logic [11:0] parallel_data_lines_i,
    output logic [11:0]      parallel_data_lines_o,
    output logic             parallel_data_lines_oe_o,
    output logic             done_n_o,
    input  wire logic        ext_clk_i,
    output logic [2:0]       channel_sel_o
);
    aps_pkg::aps_core_t s, n;
    aps_pkg::aps_pins_t pin;
    logic               tick;
    logic               wr_rise;
    logic               rd_fall;
    logic               rd_rise;
    logic               finish;
    logic [1:0]         pwr;

    function automatic logic rise(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

    function automatic logic [11:0] fmt(input logic [11:0] raw,
                                        input logic polarity_sel);
        return polarity_sel ? (raw ^ aps_pkg::BIPOLAR_FLIP) : raw;
    endfunction

    assign pin = '{cs_n: cs_n_i, wr_n: wr_n_i, rd_n: rd_n_i,
                   data: parallel_data_lines_i};
    // Write rise and read fall count only while select is low; read rise counts at any select
    assign wr_rise = ~pin.cs_n & rise(s.wr_n_p, pin.wr_n);
    assign rd_fall = ~pin.cs_n & rise(pin.rd_n, s.rd_n_p);
    assign rd_rise = rise(s.rd_n_p, pin.rd_n);
    assign finish = (s.st == aps_pkg::ST_CONV) && tick &&
                    (s.cnt == aps_pkg::CONV_TICKS - 4'h1);
    assign pwr = s.cfg[aps_pkg::CFG_PWR_HI:aps_pkg::CFG_PWR_LO];

    aps_conv_clk u_clk (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .int_sel_i (s.clk_int),
        .ext_clk_i (ext_clk_i),
        .tick_o    (tick)
    );

    always_comb begin
        logic [7:0] cb;
        logic [1:0] pw;
        cb = pin.data[7:0];
        pw = cb[aps_pkg::CFG_PWR_HI:aps_pkg::CFG_PWR_LO];
        n = s;
        n.wr_n_p = pin.wr_n;
        n.rd_n_p = pin.rd_n;
        n.ack = 1'b0;

        case (s.st)
            aps_pkg::ST_IDLE: begin
                if (wr_rise) begin
                    n.cfg = cb;
                    if (pw == aps_pkg::PWR_NORM_EXT ||
                        pw == aps_pkg::PWR_NORM_INT) begin
                        n.clk_int = pw[0];
                        n.cnt = 4'h0;
                        n.st = cb[aps_pkg::CFG_ACQ_SRC] ?
                               aps_pkg::ST_ACQ_EXT :
                               aps_pkg::ST_ACQ_INT;
                    end
                end
            end
            aps_pkg::ST_ACQ_INT: begin
                if (tick) begin
                    if (s.cnt == aps_pkg::ACQ_TICKS - 4'h1) begin
                        n.cnt = 4'h0;
                        n.st = aps_pkg::ST_CONV;
                    end else begin
                        n.cnt = s.cnt + 4'h1;
                    end
                end
            end
            aps_pkg::ST_ACQ_EXT: begin
                if (wr_rise) begin
                    n.cfg = cb;
                    n.cnt = 4'h0;
                    n.st = aps_pkg::ST_CONV;
                end
            end
            aps_pkg::ST_CONV: begin
                if (tick) begin
                    n.cnt = s.cnt + 4'h1;
                end
                if (finish) begin
                    n.cnt = 4'h0;
                    n.st = aps_pkg::ST_IDLE;
                    if (s.cfg[aps_pkg::CFG_CH_HI:0] > aps_pkg::CH_LAST) begin
                        n.result = aps_pkg::RESULT_RESET;
                        n.bad_ch = 1'b1;
                    end else begin
                        n.result = fmt(s.sample,
                                       s.cfg[aps_pkg::CFG_POLARITY]);
                        n.bad_ch = 1'b0;
                    end
                end
            end
            default: begin
                n.st = aps_pkg::ST_IDLE;
            end
        endcase

        // Read side; a finishing conversion wins over the clear
        if (rd_fall) begin
            n.oe = 1'b1;
            n.dout = s.result;
            n.done_n = 1'b1;
        end
        if (finish) begin
            n.done_n = 1'b0;
        end
        if (pin.cs_n || rd_rise) begin
            n.oe = 1'b0;
        end

        // Wishbone slave, one wait state
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            n.ack = 1'b1;
            n.rdat = 32'h0000_0000;
            if (wb_adr_i == aps_pkg::REG_CONFIG) begin
                n.rdat[7:0] = s.cfg;
            end else if (wb_adr_i == aps_pkg::REG_STATUS) begin
                n.rdat[aps_pkg::STS_DONE] = ~s.done_n;
                n.rdat[aps_pkg::STS_BUSY] = s.st != aps_pkg::ST_IDLE;
                n.rdat[aps_pkg::STS_CLK_INT] = s.clk_int;
                n.rdat[aps_pkg::STS_PWRDN] = pwr[1];
                n.rdat[aps_pkg::STS_BAD_CH] = s.bad_ch;
                n.rdat[aps_pkg::STS_ST_LO +: 2] = s.st;
            end else if (wb_adr_i == aps_pkg::REG_RESULT) begin
                n.rdat[11:0] = s.result;
            end else if (wb_adr_i == aps_pkg::REG_SAMPLE) begin
                n.rdat[11:0] = s.sample;
                if (wb_we_i && wb_sel_i[0]) begin
                    n.sample[7:0] = wb_dat_i[7:0];
                end
                if (wb_we_i && wb_sel_i[1]) begin
                    n.sample[11:8] = wb_dat_i[11:8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.cfg <= aps_pkg::CFG_RESET;
            s.done_n <= 1'b1;
            s.wr_n_p <= 1'b1;
            s.rd_n_p <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign parallel_data_lines_o = s.dout;
    assign parallel_data_lines_oe_o = s.oe;
    assign done_n_o = s.done_n;
    assign channel_sel_o = s.cfg[aps_pkg::CFG_CH_HI:0];

    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence rd_start;
        rd_fall ##0 !pin.cs_n;
    endsequence
    sequence bus_driven(logic [11:0] v);
        parallel_data_lines_oe_o && parallel_data_lines_o == v;
    endsequence
    sequence norm_wr(logic ext);
        s.st == aps_pkg::ST_IDLE && wr_rise && !pin.data[7] &&
        pin.data[aps_pkg::CFG_ACQ_SRC] == ext;
    endsequence

    chk_done_low: assert property (finish |=> !done_n_o)
        else $error("done not asserted after conversion");
    chk_read_drive: assert property (
        rd_start ##0 !finish |=> bus_driven($past(s.result)))
        else $error("result not driven on read");
    chk_int_acq: assert property (
        norm_wr(1'b0) |=> s.st == aps_pkg::ST_ACQ_INT)
        else $error("internal acquisition did not start");
    chk_ext_acq: assert property (
        norm_wr(1'b1) |=> s.st == aps_pkg::ST_ACQ_EXT)
        else $error("external acquisition did not start");
    chk_ext_end: assert property (
        s.st == aps_pkg::ST_ACQ_EXT |=> s.st == ($past(wr_rise) ?
            aps_pkg::ST_CONV : aps_pkg::ST_ACQ_EXT))
        else $error("external acquisition end wrong");
    chk_done_clear: assert property (
        rd_fall && !finish |-> ##1 done_n_o)
        else $error("done not cleared by read");
    chk_bus_release: assert property (
        rd_rise && !rd_fall |=> !parallel_data_lines_oe_o)
        else $error("data lines not released");
    chk_cs_float: assert property (
        cs_n_i |=> !parallel_data_lines_oe_o && $stable(s.cfg))
        else $error("select high did not float bus");
    chk_acq_len: assert property (
        s.st == aps_pkg::ST_ACQ_INT && tick && s.cnt == 4'h5
        |=> s.st == aps_pkg::ST_CONV)
        else $error("internal acquisition length wrong");
    chk_pwr_down: assert property (
        s.st == aps_pkg::ST_IDLE && wr_rise && pin.data[7]
        |=> s.st == aps_pkg::ST_IDLE && $stable(s.clk_int))
        else $error("power-down code started conversion");
    chk_format: assert property (
        finish && s.cfg[2:0] <= 3'h5
        |=> s.result[10:0] == $past(s.sample[10:0]) &&
            s.result[11] == ($past(s.sample[11]) ^ $past(s.cfg[3])))
        else $error("result format wrong");
    chk_bad_ch: assert property (
        finish && s.cfg[2:0] > 3'h5 |=> s.result == 12'h000 && s.bad_ch)
        else $error("invalid channel not handled");
endmodule // aps_sequencer
`default_nettype wire

// *** dv/aps_host_model.sv ***
`default_nettype none
// Bus master on the shared parallel bus
module aps_host_model (
    input  wire logic        clk_i,
    input  wire logic [11:0] dut_dat_i,
    input  wire logic        dut_oe_i,
    input  wire logic        done_n_i,
    output logic             cs_n_o,
    output logic             wr_n_o,
    output logic             rd_n_o,
    output logic [11:0]      bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        drv_q  = 1'b0;
    logic [11:0] hd_q   = 12'h000;
    logic [11:0] last_q = 12'h000;
    initial begin
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
    end
    // Undriven bus shows a changing pattern
    assign bus_o = drv_q ? hd_q : (dut_oe_i ? dut_dat_i : ~last_q);
    always @(posedge clk_i) begin
        last_q <= bus_o;
    end
    // Data held through the edge that sees wr_n high
    task automatic write_cfg(input logic [7:0] cfg, input logic sel);
        @(posedge clk_i);
        cs_n_o <= ~sel;
        wr_n_o <= 1'b0;
        drv_q  <= 1'b1;
        hd_q   <= {4'h0, cfg};
        @(posedge clk_i);
        wr_n_o <= 1'b1;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        drv_q  <= 1'b0;
    endtask
    // Select driven low on the same edge as the read strobe falls
    task automatic read_res(input logic sel, output logic [11:0] d,
                            output logic dn, output logic oe_end);
        @(posedge clk_i);
        cs_n_o <= ~sel;
        rd_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        d  = bus_o;
        dn = done_n_i;
        @(posedge clk_i);
        rd_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        oe_end = dut_oe_i;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule // aps_host_model
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cs_n, wr_n, rd_n, oe, done_n_o;
    logic        ext_clk = 1'b0;
    logic [11:0] bus, dout;
    logic [2:0]  channel_sel_o;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] r;
    logic [11:0] d;
    logic        dn, oe_end;
    int          n, lo;
    logic [7:0]  cfg_tab [5] = '{8'h41, 8'h4a, 8'h46, 8'h05, 8'h5d};
    logic [11:0] exp_tab [5] = '{12'h123, 12'h923, 12'h000, 12'h123,
                                 12'h923};

    initial forever #50 clk_i = ~clk_i;
    // Free-running 2 MHz conversion clock from the system
    initial begin
        #30;
        forever #250 ext_clk = ~ext_clk;
    end

    aps_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
        .parallel_data_lines_i(bus), .parallel_data_lines_o(dout),
        .parallel_data_lines_oe_o(oe), .done_n_o(done_n_o),
        .ext_clk_i(ext_clk), .channel_sel_o(channel_sel_o));
    aps_host_model host (.clk_i(clk_i), .dut_dat_i(dout), .dut_oe_i(oe),
        .done_n_i(done_n_o), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .bus_o(bus));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [3:0] adr,
                           input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_done(output int k);
        k = 0;
        while (done_n_o !== 1'b0 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 400) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'(done_n_o), 32'h1);
        chk(32'(oe), 32'h0);
        wb_xfer(1'b0, aps_pkg::REG_CONFIG, 32'h0, r);
        chk(r, 32'h0);
        wb_xfer(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(r, 32'h0);
        wb_xfer(1'b1, 4'h2, 32'h0fff, r);
        wb_xfer(1'b0, 4'h2, 32'h0, r);
        chk(r, 32'h0);
        wb_xfer(1'b1, aps_pkg::REG_SAMPLE, 32'h0123, r);
        wb_xfer(1'b0, aps_pkg::REG_SAMPLE, 32'h0, r);
        chk(r, 32'h0123);
        for (int i = 0; i < 5; i++) begin
            host.write_cfg(cfg_tab[i], 1'b1);
            wait_done(n);
            lo = cfg_tab[i][6] ? 100 : 80;
            chk(32'(n >= lo && n <= lo + 20), 32'h1);
            chk(32'(channel_sel_o), 32'(cfg_tab[i][2:0]));
            wb_xfer(1'b0, aps_pkg::REG_RESULT, 32'h0, r);
            chk(r, 32'(exp_tab[i]));
            wb_xfer(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
            chk(32'(r[4:2]), 32'({cfg_tab[i][2:1] == 2'h3, 1'b0,
                cfg_tab[i][6]}));
            host.read_res(1'b1, d, dn, oe_end);
            chk(32'(d), 32'(exp_tab[i]));
            chk(32'(dn), 32'h1);
            chk(32'(oe_end), 32'h0);
        end
        host.write_cfg(8'h61, 1'b1);
        repeat (30) @(posedge clk_i);
        wb_xfer(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(32'(r[6:5]), 32'h2);
        chk(32'(done_n_o), 32'h1);
        host.write_cfg(8'h41, 1'b1);
        wait_done(n);
        chk(32'(n >= 60 && n <= 90), 32'h1);
        host.read_res(1'b0, d, dn, oe_end);
        chk(32'(dn), 32'h0);
        chk(32'(oe_end), 32'h0);
        host.write_cfg(8'h80, 1'b0);
        wb_xfer(1'b0, aps_pkg::REG_CONFIG, 32'h0, r);
        chk(r, 32'h41);
        host.read_res(1'b1, d, dn, oe_end);
        chk(32'(d), 32'h123);
        host.write_cfg(8'h80, 1'b1);
        repeat (150) @(posedge clk_i);
        chk(32'(done_n_o), 32'h1);
        wb_xfer(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(32'(r[3:1]), 32'h6);
        host.write_cfg(8'hc1, 1'b1);
        wb_xfer(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(32'(r[6:1]), 32'h06);
        chk(32'(channel_sel_o), 32'h1);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
